/* File: design/fmc_pkg.sv */
// shared constants and types for the flash mode control block
package fmc_pkg;

    // ------------------------------------------------------------
    // register map and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] FMC_CTRL_ADDR = 16'hff80;
    localparam logic [15:0] FMC_GAP_ADDR = 16'hff81;
    localparam logic [15:0] FMC_LARGE_ADDR = 16'hff82;
    localparam logic [15:0] FMC_SMALL_ADDR = 16'hff83;
    localparam logic [15:0] FMC_WAIT_ADDR = 16'hffc2;
    localparam logic [7:0] FMC_CTRL_RESET = 8'h00;
    localparam logic [7:0] FMC_SEL_RESET = 8'h00;
    localparam logic [7:0] FMC_WAIT_RESET = 8'h08;
    localparam logic [7:0] FMC_FIXED_READ = 8'hff;
    localparam logic [7:0] FMC_LARGE_LOCK_M2 = 8'h80;
    localparam logic [7:0] FMC_NO_LOCK = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int FMC_VPP_BIT = 7;
    localparam int FMC_EV_BIT = 3;
    localparam int FMC_PV_BIT = 2;
    localparam int FMC_E_BIT = 1;
    localparam int FMC_P_BIT = 0;
    localparam int FMC_RAMS_BIT = 7;
    localparam int FMC_RAM0_BIT = 6;

    // ------------------------------------------------------------
    // flash window ends per mode
    // ------------------------------------------------------------
    localparam logic [15:0] FMC_END_MODE2 = 16'hef7f;
    localparam logic [15:0] FMC_END_MODE3 = 16'hf77f;

    // ------------------------------------------------------------
    // boot loader bit-rate alignment timing
    // ------------------------------------------------------------
    localparam int FMC_CLK_HZ = 100_000_000;
    localparam int FMC_BOOT_MAX_BPS = 9600;
    // least bit time rounds up to whole cycles
    localparam int FMC_BOOT_MIN_BIT_CYC = (FMC_CLK_HZ + FMC_BOOT_MAX_BPS - 1) / FMC_BOOT_MAX_BPS;
    localparam int FMC_BOOT_LOW_BITS = 9;
    localparam int FMC_BAUD_W = 20;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FMC_MODE_ILLEGAL = 2'h0,
        FMC_MODE_EXT = 2'h1,
        FMC_MODE_ROM2 = 2'h2,
        FMC_MODE_ROM3 = 2'h3
    } fmc_mode_t;

    typedef enum logic [2:0] {
        FMC_OP_READ = 3'h0,
        FMC_OP_PROGRAM = 3'h1,
        FMC_OP_PVERIFY = 3'h3,
        FMC_OP_PREWRITE = 3'h7,
        FMC_OP_ERASE = 3'h2,
        FMC_OP_EVERIFY = 3'h6
    } fmc_op_t;

    typedef struct packed {
        logic [15:0] addr;
        logic rd;
        logic wr;
        logic word;
        logic [15:0] wdata;
    } fmc_bus_req_t;

endpackage

/* File: design/fmc_sel_reg.sv */
// block-select register with per-bit write lock
`timescale 1ns/1ps
`default_nettype none

module fmc_sel_reg (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic clear_in,
    input wire logic write_in,
    input wire logic [7:0] lock_mask_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] bits_out
);
    import fmc_pkg::*;

    logic [7:0] next_bits;

    // locked bits keep their value through a write; clear beats a write and the lock
    assign next_bits = clear_in ? FMC_SEL_RESET :
                       write_in ? ((wdata_in & ~lock_mask_in) | (bits_out & lock_mask_in)) :
                       bits_out;

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            bits_out <= FMC_SEL_RESET;
        end else begin
            bits_out <= next_bits;
        end
    end

endmodule

`default_nettype wire

/* File: design/fmc_ctrl.sv */
// flash mode control: mode decode, programming-supply gating, mode bits
// How it works
// - sixteen-bit path, byte and word in two states
// - window ends EF7F in mode 2, F77F mode 3
// - mode pins: 00 illegal, 01 external, else flash
// - five operations besides normal read
// - eight large and eight small selectable blocks
// - control and block registers reachable only with 12 V present
// - no 12 V: mode 2 external, mode 3 FF
// - mode 1: control and block registers ignore writes, read FF
// - control clears; reads 80 with 12 V
// - bit 7 shows programming supply present
// - bits 6 to 4 read zero
// - bit 3 selects erase-verify
// - bit 2 selects program-verify
// - bit 1 selects erase
// - bit 0 selects program
// - boot receiver aligns rate up to 9600 bps
// - block bits enable blocks, clear like control
// - mode 2 large block bit 7 locked
`timescale 1ns/1ps
`default_nettype none

module fmc_ctrl #(
    parameter int BOOT_MIN_BIT_CYC = fmc_pkg::FMC_BOOT_MIN_BIT_CYC
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic standby_in,
    input wire logic mode_pin_high_in,
    input wire logic mode_pin_low_in,
    input wire logic programming_power_pin_in,
    input wire fmc_pkg::fmc_bus_req_t bus_req_in,
    input wire logic [15:0] array_rdata_in,
    input wire logic boot_mode_in,
    input wire logic boot_rxd_in,
    output logic [15:0] rdata_out,
    output logic ack_out,
    output logic ext_sel_out,
    output logic illegal_mode_out,
    output logic array_wr_out,
    output logic [15:0] array_addr_out,
    output logic [15:0] array_wdata_out,
    output fmc_pkg::fmc_op_t op_state_out,
    output logic [7:0] large_block_out,
    output logic [7:0] small_block_out,
    output logic [7:0] wait_and_overlay_out,
    output logic baud_locked_out,
    output logic [fmc_pkg::FMC_BAUD_W-1:0] baud_bit_cycles_out
);
    import fmc_pkg::*;

    // ------------------------------------------------------------
    // mode decode and address windows
    // ------------------------------------------------------------
    fmc_mode_t mode;
    logic vpp, flash_on, mode2, mode3, in_flash, reg_area, regs_live;
    logic reg_external, reg_fixed, req, is_ext;
    logic [15:0] addr, window_end;

    assign mode = fmc_mode_t'({mode_pin_high_in, mode_pin_low_in});
    assign vpp = programming_power_pin_in;
    assign mode2 = (mode == FMC_MODE_ROM2);
    assign mode3 = (mode == FMC_MODE_ROM3);
    assign flash_on = mode2 | mode3;
    assign addr = bus_req_in.addr;
    assign req = bus_req_in.rd | bus_req_in.wr;
    assign window_end = mode3 ? FMC_END_MODE3 : FMC_END_MODE2;
    assign in_flash = flash_on && (addr <= window_end);
    assign reg_area = (addr[15:2] == FMC_CTRL_ADDR[15:2]);
    // registers exist only while the supply is up in a flash mode
    assign regs_live = flash_on && vpp;
    assign reg_external = reg_area && mode2 && !vpp;
    // mode 1 and supply-less mode 3 give a frozen all-ones area
    assign reg_fixed = reg_area && (!flash_on || (mode3 && !vpp));
    assign is_ext = !in_flash && !(reg_area && !reg_external) && (addr != FMC_WAIT_ADDR);

    // ------------------------------------------------------------
    // byte lanes: big-endian, even address on the high lane
    // ------------------------------------------------------------
    // functions read only their arguments, so every net re-evaluates on change
    function automatic logic wr_hit(input logic [15:0] a, input fmc_bus_req_t r);
        wr_hit = r.wr && ((r.addr == a) || (r.word && (r.addr[15:1] == a[15:1])));
    endfunction

    logic wr_ctrl, wr_large, wr_small, wr_wait;
    logic [7:0] even_wbyte, odd_wbyte;
    // even registers take the high lane of a word write
    assign even_wbyte = bus_req_in.word ? bus_req_in.wdata[15:8] : bus_req_in.wdata[7:0];
    assign odd_wbyte = bus_req_in.wdata[7:0];

    // control and block-select writes land only while the registers are live; wait writes always land
    assign wr_ctrl = regs_live && wr_hit(FMC_CTRL_ADDR, bus_req_in);
    assign wr_large = regs_live && wr_hit(FMC_LARGE_ADDR, bus_req_in);
    assign wr_small = regs_live && wr_hit(FMC_SMALL_ADDR, bus_req_in);
    assign wr_wait = bus_req_in.wr && (addr == FMC_WAIT_ADDR);

    // ------------------------------------------------------------
    // control register: supply flag plus four operation bits
    // ------------------------------------------------------------
    logic [3:0] ctrl_bits, next_ctrl_bits;
    logic [7:0] ctrl_value, ctrl_wbyte;

    assign ctrl_wbyte = even_wbyte;
    // standby or a missing supply wipes the mode bits on the next edge
    assign next_ctrl_bits = (standby_in || !vpp) ? FMC_CTRL_RESET[3:0] :
                            wr_ctrl ? ctrl_wbyte[3:0] : ctrl_bits;
    // reserved bits are constant zero, bit 7 mirrors the supply
    assign ctrl_value = {vpp, 3'h0, ctrl_bits};

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            ctrl_bits <= FMC_CTRL_RESET[3:0];
        end else begin
            ctrl_bits <= next_ctrl_bits;
        end
    end

    // ------------------------------------------------------------
    // block-select registers
    // ------------------------------------------------------------
    logic sel_clear;
    logic [7:0] large_lock;

    assign sel_clear = standby_in || !vpp;
    assign large_lock = mode2 ? FMC_LARGE_LOCK_M2 : FMC_NO_LOCK;

    // one bit per block, eight large and eight small
    fmc_sel_reg u_large (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .clear_in(sel_clear),
        .write_in(wr_large),
        .lock_mask_in(large_lock),
        .wdata_in(even_wbyte),
        .bits_out(large_block_out)
    );

    fmc_sel_reg u_small (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .clear_in(sel_clear),
        .write_in(wr_small),
        .lock_mask_in(FMC_NO_LOCK),
        .wdata_in(odd_wbyte),
        .bits_out(small_block_out)
    );

    // ------------------------------------------------------------
    // wait and overlay register; survives standby
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            wait_and_overlay_out <= FMC_WAIT_RESET;
        end else if (wr_wait) begin
            wait_and_overlay_out <= even_wbyte;
        end
    end

    // ------------------------------------------------------------
    // operation state
    // ------------------------------------------------------------
    logic protect, blocks_any, arm, zero_pgm;
    fmc_op_t next_op;

    // one overlay bit alone means ram emulation: no program or erase
    assign protect = wait_and_overlay_out[FMC_RAMS_BIT] ^ wait_and_overlay_out[FMC_RAM0_BIT];
    assign blocks_any = (|large_block_out) | (|small_block_out);
    assign arm = vpp && blocks_any && !protect;

    // fixed priority if software breaks the one-bit-at-a-time habit
    always_comb begin
        next_op = FMC_OP_READ;
        if (ctrl_bits[FMC_P_BIT] && arm) begin
            next_op = FMC_OP_PROGRAM;
        end else if (ctrl_bits[FMC_E_BIT] && arm) begin
            next_op = FMC_OP_ERASE;
        end else if (ctrl_bits[FMC_PV_BIT] && vpp) begin
            next_op = zero_pgm ? FMC_OP_PREWRITE : FMC_OP_PVERIFY;
        end else if (ctrl_bits[FMC_EV_BIT] && vpp) begin
            next_op = FMC_OP_EVERIFY;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            op_state_out <= FMC_OP_READ;
        end else begin
            op_state_out <= next_op;
        end
    end

    // ------------------------------------------------------------
    // array programming strobe; remembers an all-zero write for prewrite
    // ------------------------------------------------------------
    logic pgm_write;

    assign pgm_write = bus_req_in.wr && in_flash && (op_state_out == FMC_OP_PROGRAM);

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            array_wr_out <= 1'b0;
            array_addr_out <= 16'h0000;
            array_wdata_out <= 16'h0000;
            zero_pgm <= 1'b0;
        end else begin
            array_wr_out <= pgm_write;
            array_addr_out <= pgm_write ? addr : array_addr_out;
            array_wdata_out <= pgm_write ? bus_req_in.wdata : array_wdata_out;
            if (pgm_write) begin
                zero_pgm <= (bus_req_in.wdata == 16'h0000);
            end else if (op_state_out == FMC_OP_ERASE) begin
                zero_pgm <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // read data: answer one cycle after the request
    // ------------------------------------------------------------
    function automatic logic [7:0] rbyte(input logic [15:0] a, input logic [32:0] bk);
        if (bk[32]) begin
            rbyte = FMC_FIXED_READ;
        end else if (a == FMC_CTRL_ADDR) begin
            rbyte = bk[31:24];
        end else if (a == FMC_LARGE_ADDR) begin
            rbyte = bk[23:16];
        end else if (a == FMC_SMALL_ADDR) begin
            rbyte = bk[15:8];
        end else if (a == FMC_WAIT_ADDR) begin
            rbyte = bk[7:0];
        end else begin
            rbyte = 8'h00;
        end
    endfunction

    logic [15:0] reg_word, flash_word, next_rdata;
    logic [15:0] even_addr, odd_addr;
    logic [32:0] regs;
    assign even_addr = {addr[15:1], 1'b0};
    assign odd_addr = {addr[15:1], 1'b1};
    assign regs = {reg_fixed, ctrl_value, large_block_out, small_block_out, wait_and_overlay_out};
    assign reg_word = bus_req_in.word ? {rbyte(even_addr, regs), rbyte(odd_addr, regs)} :
                      {8'h00, rbyte(addr, regs)};
    // array answers in the request cycle, so two states suffice
    assign flash_word = bus_req_in.word ? array_rdata_in :
                        {8'h00, addr[0] ? array_rdata_in[7:0] : array_rdata_in[15:8]};
    assign next_rdata = !bus_req_in.rd ? 16'h0000 :
                        in_flash ? flash_word :
                        is_ext ? 16'h0000 : reg_word;

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            rdata_out <= 16'h0000;
            ack_out <= 1'b0;
            ext_sel_out <= 1'b0;
            illegal_mode_out <= 1'b0;
        end else begin
            rdata_out <= next_rdata;
            ack_out <= req;
            ext_sel_out <= req && is_ext;
            illegal_mode_out <= (mode == FMC_MODE_ILLEGAL);
        end
    end

    // ------------------------------------------------------------
    // boot receiver bit-rate alignment on a leading zero byte
    // ------------------------------------------------------------
    logic rxd_prev, low_run;
    logic [FMC_BAUD_W-1:0] low_cnt, bit_est;

    // nine bit times low: start bit plus eight zero data bits
    assign bit_est = low_cnt / FMC_BAUD_W'(FMC_BOOT_LOW_BITS);

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in || !boot_mode_in) begin
            rxd_prev <= 1'b1;
            low_run <= 1'b0;
            low_cnt <= '0;
            baud_locked_out <= 1'b0;
            baud_bit_cycles_out <= '0;
        end else begin
            rxd_prev <= boot_rxd_in;
            if (!baud_locked_out && !boot_rxd_in && !(&low_cnt)) begin
                low_run <= 1'b1;
                low_cnt <= low_cnt + 1'b1;
            end else if (!baud_locked_out && low_run && boot_rxd_in && !rxd_prev) begin
                low_run <= 1'b0;
                low_cnt <= '0;
                // faster than the top rate is ignored and re-measured
                baud_locked_out <= (bit_est >= FMC_BAUD_W'(BOOT_MIN_BIT_CYC));
                baud_bit_cycles_out <= bit_est;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking fmc_cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    a_two_state_ack: assert property (req |=> ack_out)
        else $error("bus request not answered in the next cycle");
    a_window_mode2: assert property (mode2 && bus_req_in.rd && addr == 16'hef80
        |=> ext_sel_out) else $error("mode 2 window reaches past its end");
    a_vpp_flag_read: assert property (mode3 && vpp && bus_req_in.rd && !bus_req_in.word
        && addr == FMC_CTRL_ADDR |=> rdata_out[7]) else $error("supply flag not seen");
    a_reserved_zero: assert property (regs_live && bus_req_in.rd && !bus_req_in.word
        && addr == FMC_CTRL_ADDR |=> rdata_out[6:4] == 3'h0) else $error("reserved bits set");
    a_mode3_fixed: assert property (mode3 && !vpp && bus_req_in.rd && reg_area
        |=> rdata_out[7:0] == FMC_FIXED_READ) else $error("mode 3 area not all ones");
    a_mode2_external: assert property (mode2 && !vpp && req && reg_area
        |=> ext_sel_out && rdata_out == 16'h0000) else $error("mode 2 area not external");
    a_mode1_frozen: assert property (mode == FMC_MODE_EXT && req && reg_area
        |=> ctrl_bits == $past(ctrl_bits)) else $error("mode 1 write took effect");
    a_ctrl_clear: assert property (!vpp ##1 !vpp |-> ctrl_bits == 4'h0
        && op_state_out == FMC_OP_READ) else $error("mode bits survive supply loss");
    a_select_clear: assert property (standby_in |=> large_block_out == 8'h00
        && small_block_out == 8'h00) else $error("block selects survive standby");
    a_large_lock: assert property (mode2 && wr_large
        |=> large_block_out[7] == $past(large_block_out[7])) else $error("locked bit moved");
    a_program_arm: assert property (op_state_out == FMC_OP_PROGRAM
        |-> $past(arm) && $past(ctrl_bits[FMC_P_BIT])) else $error("program without arming");
    a_erase_entry: assert property (ctrl_bits == 4'h2 && arm ##1 ctrl_bits == 4'h2
        |-> op_state_out == FMC_OP_ERASE) else $error("erase bit ignored");

    c_program: cover property (op_state_out == FMC_OP_PROGRAM ##1 array_wr_out);
    c_erase: cover property (op_state_out == FMC_OP_ERASE);
    c_prewrite: cover property (op_state_out == FMC_OP_PREWRITE);
    c_baud_lock: cover property ($rose(baud_locked_out));

endmodule

`default_nettype wire

/* File: tb/fmc_cpu_model.sv */
// cpu-side bus master model driving the flash mode control block
`timescale 1ns/1ps
`default_nettype none

module fmc_cpu_model
    import fmc_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic ack_in,
    input wire logic ext_sel_in,
    input wire logic [15:0] rdata_in,
    output var fmc_pkg::fmc_bus_req_t bus_req_out
);
    // one access: strobe held for one taking edge, answer read one cycle on
    task automatic xfer(input logic [15:0] a, input logic w, input logic wd,
            input logic [15:0] d, output logic [15:0] r, output logic ak,
            output logic ex);
        @(posedge sys_clk_in);
        bus_req_out <= '{addr: a, rd: ~w, wr: w, word: wd, wdata: d};
        @(posedge sys_clk_in);
        // released fields carry garbage, never the last value
        bus_req_out <= '{addr: ~a, rd: 1'b0, wr: 1'b0, word: ~wd, wdata: ~d};
        @(negedge sys_clk_in);
        r = rdata_in;
        ak = ack_in;
        ex = ext_sel_in;
    endtask

    // idle bus at time zero
    initial begin
        bus_req_out = '{addr: 16'h0000, rd: 1'b0, wr: 1'b0, word: 1'b0, wdata: 16'h0000};
    end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for fmc_ctrl against a behavioural register model
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import fmc_pkg::*;
    localparam int MIN_BIT = 20;
    logic sys_clk, reset_n, standby, mode_pin_high, mode_pin_low, vpp, boot_mode, boot_rxd;
    fmc_bus_req_t bus_req;
    logic [15:0] array_rdata, rdata, array_addr, array_wdata, t_r, a;
    logic ack, ext_sel, illegal, array_wr, baud_locked, t_ak, t_ex;
    fmc_op_t op_state;
    logic [7:0] large_blk, small_blk, wait_ov, d;
    logic [FMC_BAUD_W-1:0] baud_cyc;
    int n_errors = 0;
    int n_checks = 0;
    int m_mode, m_ctrl, m_large, m_small, m_wait;
    int modes[4] = '{1, 2, 3, 0};
    logic [15:0] addrs[4] = '{FMC_CTRL_ADDR, FMC_LARGE_ADDR, FMC_SMALL_ADDR, FMC_WAIT_ADDR};
    logic [7:0] ops[4] = '{8'h01, 8'h02, 8'h04, 8'h08};
    fmc_op_t exp_op[4] = '{FMC_OP_PROGRAM, FMC_OP_ERASE, FMC_OP_PVERIFY, FMC_OP_EVERIFY};

    // array data follows the address so a stale word cannot pass
    assign array_rdata = bus_req.addr ^ 16'h5a3c;

    fmc_ctrl #(.BOOT_MIN_BIT_CYC(MIN_BIT)) uut (.sys_clk_in(sys_clk), .reset_n_in(reset_n),
        .standby_in(standby), .mode_pin_high_in(mode_pin_high),
        .mode_pin_low_in(mode_pin_low), .programming_power_pin_in(vpp),
        .bus_req_in(bus_req), .array_rdata_in(array_rdata), .boot_mode_in(boot_mode),
        .boot_rxd_in(boot_rxd), .rdata_out(rdata), .ack_out(ack), .ext_sel_out(ext_sel),
        .illegal_mode_out(illegal), .array_wr_out(array_wr), .array_addr_out(array_addr),
        .array_wdata_out(array_wdata), .op_state_out(op_state),
        .large_block_out(large_blk), .small_block_out(small_blk),
        .wait_and_overlay_out(wait_ov), .baud_locked_out(baud_locked),
        .baud_bit_cycles_out(baud_cyc));

    fmc_cpu_model cpu (.sys_clk_in(sys_clk), .ack_in(ack), .ext_sel_in(ext_sel),
        .rdata_in(rdata), .bus_req_out(bus_req));

    // 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic stop_test();
        if (n_errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // reset also resets the model; mode pins settle under reset
    task automatic do_reset(input int md);
        @(posedge sys_clk);
        reset_n <= 1'b0;
        mode_pin_high <= md[1];
        mode_pin_low <= md[0];
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        m_mode = md;
        m_ctrl = 0;
        m_large = 0;
        m_small = 0;
        m_wait = 8;
    endtask

    // supply change: dropping it clears control and selects next edge
    task automatic set_vpp(input logic v);
        @(posedge sys_clk);
        vpp <= v;
        if (!v) begin
            m_ctrl = 0;
            m_large = 0;
            m_small = 0;
        end
        @(posedge sys_clk);
    endtask

    // byte register access checked against the model
    task automatic reg_acc(input logic [15:0] ra, input logic w, input logic [7:0] wd);
        bit gate;
        bit x;
        int e;
        gate = m_mode >= 2 && vpp;
        x = m_mode == 2 && !vpp && ra != FMC_WAIT_ADDR;
        if (ra == FMC_WAIT_ADDR) e = m_wait;
        else if (!gate) e = x ? 0 : 'hff;
        else if (ra == FMC_CTRL_ADDR) e = 'h80 | m_ctrl;
        else if (ra == FMC_LARGE_ADDR) e = m_large;
        else e = m_small;
        if (w) begin
            e = 0;
            if (ra == FMC_WAIT_ADDR) m_wait = wd;
            else if (gate && ra == FMC_CTRL_ADDR) m_ctrl = wd & 'h0f;
            else if (gate && ra == FMC_LARGE_ADDR) m_large = m_mode == 2 ? wd & 'h7f : wd;
            else if (gate) m_small = wd;
        end
        cpu.xfer(ra, w, 1'b0, {8'h00, wd}, t_r, t_ak, t_ex);
        chk({15'h0, t_ak}, 16'h0001, "ack");
        chk({15'h0, t_ex}, {15'h0, x}, "external select");
        chk(t_r, e[15:0], "register data");
        chk({large_blk, small_blk}, {m_large[7:0], m_small[7:0]}, "selects");
        chk({8'h00, wait_ov}, m_wait[15:0], "wait register");
    endtask

    // word read either side of the flash window end
    task automatic win_chk(input int md, input logic [15:0] wa, input bit in_win);
        do_reset(md);
        cpu.xfer(wa, 1'b0, 1'b1, 16'h0000, t_r, t_ak, t_ex);
        chk(t_r, in_win ? wa ^ 16'h5a3c : 16'h0000, "window data");
        chk({15'h0, t_ex}, {15'h0, !in_win}, "window select");
    endtask

    // low run of nine bit times, then a rise
    task automatic baud(input int bits);
        @(posedge sys_clk);
        boot_rxd <= 1'b0;
        repeat (9 * bits) @(posedge sys_clk);
        boot_rxd <= 1'b1;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(baud_cyc[15:0], bits[15:0], "bit period");
        chk({15'h0, baud_locked}, {15'h0, bits >= MIN_BIT}, "rate lock");
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        standby = 1'b0;
        mode_pin_high = 1'b1;
        mode_pin_low = 1'b1;
        vpp = 1'b0;
        boot_mode = 1'b0;
        boot_rxd = 1'b1;
        void'($urandom(80));
        // random register traffic per mode with the supply toggling
        foreach (modes[i]) begin
            do_reset(modes[i]);
            @(posedge sys_clk); // flag follows the pins from the first edge after release
            @(negedge sys_clk);
            chk({15'h0, illegal}, {15'h0, modes[i] == 0}, "illegal mode");
            for (int k = 0; k < 40; k++) begin
                if ($urandom_range(7) == 0) set_vpp(!vpp);
                a = addrs[$urandom_range(3)];
                d = 8'($urandom);
                if (a == FMC_CTRL_ADDR) d = (8'h01 << $urandom_range(4)) & 8'h0f;
                reg_acc(a, 1'($urandom_range(1)), d);
            end
        end
        win_chk(2, 16'hef7e, 1'b1);
        win_chk(2, 16'hef80, 1'b0);
        win_chk(3, 16'hf77e, 1'b1);
        win_chk(3, 16'hf780, 1'b0);
        win_chk(1, 16'h0000, 1'b0);
        // operation selection; program needs a block first
        do_reset(3);
        set_vpp(1'b1);
        reg_acc(FMC_CTRL_ADDR, 1'b1, 8'hf0);
        reg_acc(FMC_CTRL_ADDR, 1'b0, 8'h00);
        reg_acc(FMC_CTRL_ADDR, 1'b1, 8'h01);
        @(negedge sys_clk);
        chk({13'h0, op_state}, {13'h0, FMC_OP_READ}, "op without block");
        reg_acc(FMC_SMALL_ADDR, 1'b1, 8'h01);
        foreach (ops[i]) begin
            reg_acc(FMC_CTRL_ADDR, 1'b1, ops[i]);
            @(negedge sys_clk);
            chk({13'h0, op_state}, {13'h0, exp_op[i]}, "op state");
            if (i == 0) begin
                cpu.xfer(16'h0010, 1'b1, 1'b1, 16'h1234, t_r, t_ak, t_ex);
                chk({15'h0, array_wr}, 16'h0001, "array strobe");
                chk(array_addr, 16'h0010, "array address");
                chk(array_wdata, 16'h1234, "array data");
            end
            reg_acc(FMC_CTRL_ADDR, 1'b1, 8'h00);
        end
        // an all-zero program write turns program-verify into prewrite-verify
        reg_acc(FMC_CTRL_ADDR, 1'b1, 8'h01);
        cpu.xfer(16'h0020, 1'b1, 1'b1, 16'h0000, t_r, t_ak, t_ex);
        chk({15'h0, array_wr}, 16'h0001, "zero write strobe");
        chk(array_wdata, 16'h0000, "zero write data");
        reg_acc(FMC_CTRL_ADDR, 1'b1, 8'h04);
        @(negedge sys_clk);
        chk({13'h0, op_state}, {13'h0, FMC_OP_PREWRITE}, "prewrite op");
        // standby wipes control and selects but keeps the supply flag
        reg_acc(FMC_CTRL_ADDR, 1'b1, 8'h02);
        @(posedge sys_clk);
        standby <= 1'b1;
        @(posedge sys_clk);
        standby <= 1'b0;
        m_ctrl = 0;
        m_small = 0;
        reg_acc(FMC_CTRL_ADDR, 1'b0, 8'h00);
        @(posedge sys_clk);
        boot_mode <= 1'b1;
        baud(10);
        baud(MIN_BIT + $urandom_range(8));
        stop_test();
    end

    // hang guard: 40,000 cycles, far beyond the fewer than a thousand used
    initial begin
        #400_000;
        n_errors++;
        stop_test();
    end
endmodule
`default_nettype wire
